// file: hdl/cascade_pkg.sv
// Purpose: Shared constants for the cascaded display RAM write addressing.
// Assumes: One 100 MHz clock; byte-level link abstraction of the serial bus.
// Notes: Command encodings other than the pointer load are local choices.
package cascade_pkg;
  // ----------------------------------------------------------------------
  // Display RAM geometry
  // ----------------------------------------------------------------------
  localparam int RAM_WORDS = 40;
  localparam int PTR_W = 6;
  localparam int ROWS = 4;
  localparam int SUB_W = 3;
  localparam logic [PTR_W-1:0] PTR_RESET = 6'h00;
  localparam logic [SUB_W-1:0] SUB_RESET = 3'h0;

  // ----------------------------------------------------------------------
  // Bus address and command byte fields
  // ----------------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR = 7'h38;
  localparam int CONT_BIT = 7;
  localparam int OP_BIT = 6;
  localparam int SEL_LSB = 3;
  localparam logic [2:0] OP_SELECT_UNIT = 3'h7;
  localparam logic [2:0] OP_SET_MODE = 3'h4;

  // ----------------------------------------------------------------------
  // Multiplex drive modes
  // ----------------------------------------------------------------------
  localparam logic [1:0] MODE_STATIC = 2'h0;
  localparam logic [1:0] MODE_MUX2 = 2'h1;
  localparam logic [1:0] MODE_MUX3 = 2'h2;
  localparam logic [1:0] MODE_MUX4 = 2'h3;
  localparam logic [1:0] MODE_RESET = 2'h3;

  // ----------------------------------------------------------------------
  // Timing: shared cascade clock tick period
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 160;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 9;
endpackage : cascade_pkg

// file: hdl/cascade_if.sv
// Purpose: Byte-level link between bus master and one cascaded driver.
// Assumes: All signals on i_ref_clk; acknowledge is open drain.
// Notes: Bench ORs several driver enables onto the shared acknowledge.
`timescale 1ns/100ps
`default_nettype none
interface cascade_if;
  logic start;
  logic stb;
  logic [7:0] data;
  logic ext_clk;
  logic ack_out;
  logic ack_oe;
  wire ack;

  // Open drain: a driver that enables pulls the acknowledge active
  assign ack = ack_oe & ~ack_out;

  modport host (output start, output stb, output data, output ext_clk,
                input ack);
  modport device (input start, input stb, input data, input ext_clk,
                  output ack_out, output ack_oe);
endinterface : cascade_if
`default_nettype wire

// file: hdl/cascade_device.sv
// Purpose: Write addressing of one cascadable segment driver display RAM.
// Assumes: Link inputs come from logic on i_ref_clk; straps are pins.
// Notes: One data byte is fully placed in the cycle after its strobe.
// Operation
// - Pointer load command sets write address
// - Pointer advances after every data byte
// - Bits per step follow drive mode
// - Store only when counter matches strap
// - Subaddress strap is two or three bits
// - Select command loads subaddress counter
// - Mismatch suppresses write, pointer still advances
// - Overflow wraps pointer, counter increments
// - Next driver stores excess and acknowledges
// - Last driver discards excess, no acknowledge
// - Exact fill of last driver: no acknowledge
// - All drivers share one slave address
// - Common clock; external source needs select
// - Continuation flag chooses command or data
// - Pointer command carries six address bits
// - Pointer spans 0 to 39 then overflows
// - Host uses select command to span cascade
// - Host resets pointer and counter if oversized
`timescale 1ns/100ps
`default_nettype none
module cascade_device #(
  parameter int SUBADDR_BITS = 3,
  parameter int TICK_DIV = cascade_pkg::TICK_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  cascade_if.device link,
  input wire logic i_subaddr_strap_bit_zero,
  input wire logic i_subaddr_strap_bit_one,
  input wire logic i_subaddr_strap_bit_two,
  input wire logic i_oscillator_source_select,
  input wire logic i_last_in_cascade,
  input wire logic [cascade_pkg::PTR_W-1:0] i_ram_rd_addr,
  output logic [cascade_pkg::ROWS-1:0] o_ram_rd_data,
  output logic [cascade_pkg::PTR_W-1:0] o_write_pointer,
  output logic [cascade_pkg::SUB_W-1:0] o_subaddr_count,
  output logic [1:0] o_drive_mode,
  output logic o_frame_tick
);
  localparam int RW = cascade_pkg::RAM_WORDS;
  localparam int PW = cascade_pkg::PTR_W;
  localparam int SW = cascade_pkg::SUB_W;
  localparam logic [SW-1:0] SUB_MASK = SW'((1 << SUBADDR_BITS) - 1);

  typedef enum {PH_IDLE, PH_CMD, PH_DATA} phase_e;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Pointer step per byte for each drive mode
  function automatic logic [3:0] steps_of(input logic [1:0] mode);
    case (mode)
      cascade_pkg::MODE_STATIC: steps_of = 4'h8;
      cascade_pkg::MODE_MUX2: steps_of = 4'h4;
      cascade_pkg::MODE_MUX3: steps_of = 4'h3;
      default: steps_of = 4'h2;
    endcase
  endfunction : steps_of

  // Bits per RAM word (1:3 packs 3+3+2, last word row 2 untouched)
  function automatic logic [2:0] per_word(input logic [1:0] mode);
    case (mode)
      cascade_pkg::MODE_STATIC: per_word = 3'h1;
      cascade_pkg::MODE_MUX2: per_word = 3'h2;
      cascade_pkg::MODE_MUX3: per_word = 3'h3;
      default: per_word = 3'h4;
    endcase
  endfunction : per_word

  // Counter versus strap, only the strapped width takes part
  function automatic logic sub_eq(input logic [SW-1:0] cnt,
                                  input logic [SW-1:0] strap);
    sub_eq = ((cnt ^ strap) & SUB_MASK) == 3'h0;
  endfunction : sub_eq

  // ----------------------------------------------------------------------
  // Strap and external tick synchronisers
  // ----------------------------------------------------------------------
  logic [5:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_d, pin_q;
  logic [5:0] pin_raw;

  assign pin_raw = {i_oscillator_source_select, link.ext_clk,
                    i_last_in_cascade,
                    i_subaddr_strap_bit_two, i_subaddr_strap_bit_one,
                    i_subaddr_strap_bit_zero};

  // A pin level is accepted once the second and third stages agree
  always_comb begin
    for (int b = 0; b < 6; b++) begin
      pin_d[b] = (pin_s2_q[b] == pin_s3_q[b]) ? pin_s3_q[b] : pin_q[b];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      pin_s1_q <= 6'h00;
      pin_s2_q <= 6'h00;
      pin_s3_q <= 6'h00;
      pin_q <= 6'h00;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_q <= pin_d;
    end
  end

  logic [SW-1:0] strap;
  logic last_drv;
  logic osc_sel_q;

  // Bit two is dropped for a two-bit strap by the mask in sub_eq
  assign strap = pin_q[2:0];
  assign last_drv = pin_q[3];

  // ----------------------------------------------------------------------
  // Shared cascade clock tick
  // ----------------------------------------------------------------------
  // Oscillator select is a strap, so it goes through the same sampler path
  logic [7:0] div_q, div_d;
  logic ext_prev_q, tick_q, tick_d;

  always_comb begin
    div_d = (div_q == 8'(TICK_DIV - 1)) ? 8'h00 : div_q + 8'h01;
    if (osc_sel_q) begin
      tick_d = pin_q[4] & ~ext_prev_q;
    end else begin
      tick_d = (div_q == 8'h00);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      div_q <= 8'h00;
      ext_prev_q <= 1'b0;
      tick_q <= 1'b0;
      osc_sel_q <= 1'b0;
    end else begin
      div_q <= div_d;
      ext_prev_q <= pin_q[4];
      tick_q <= tick_d;
      osc_sel_q <= pin_q[5];
    end
  end

  // ----------------------------------------------------------------------
  // Command parser and RAM writer
  // ----------------------------------------------------------------------
  phase_e phase_q, phase_d;
  logic [PW-1:0] ptr_q, ptr_d;
  logic [SW-1:0] sub_q, sub_d;
  logic [1:0] mode_q, mode_d;
  logic ack_q, ack_d;
  logic [RW-1:0][cascade_pkg::ROWS-1:0] ram_q, ram_d;
  logic [3:0] rd_q, rd_d;

  // Whole byte is placed in one cycle, so no back-pressure is needed
  always_comb begin
    logic [6:0] addr;
    logic [6:0] nxt;
    logic [2:0] word;
    logic [1:0] row;
    logic excess;
    logic here;
    logic there;
    addr = 7'h00;
    nxt = 7'h00;
    word = 3'h0;
    row = 2'h0;
    excess = 1'b0;
    here = sub_eq(sub_q, strap);
    there = sub_eq(sub_q + 3'h1, strap);
    phase_d = phase_q;
    ptr_d = ptr_q;
    sub_d = sub_q;
    mode_d = mode_q;
    ram_d = ram_q;
    ack_d = 1'b0;
    if (link.stb && link.start) begin
      // Every driver answers the one shared address
      if (link.data[7:1] == cascade_pkg::SLAVE_ADDR && !link.data[0]) begin
        phase_d = PH_CMD;
        ack_d = 1'b1;
      end else begin
        phase_d = PH_IDLE;
      end
    end else if (link.stb && phase_q == PH_CMD) begin
      ack_d = 1'b1;
      if (!link.data[cascade_pkg::CONT_BIT]) begin
        phase_d = PH_DATA;
      end
      if (!link.data[cascade_pkg::OP_BIT]) begin
        ptr_d = link.data[PW-1:0];
      end else if (link.data[5:cascade_pkg::SEL_LSB] ==
                   cascade_pkg::OP_SELECT_UNIT) begin
        sub_d = link.data[SW-1:0];
      end else if (link.data[5:cascade_pkg::SEL_LSB] ==
                   cascade_pkg::OP_SET_MODE) begin
        mode_d = link.data[1:0];
      end
    end else if (link.stb && phase_q == PH_DATA) begin
      // Unmatched drivers run the same arithmetic to stay aligned
      for (int i = 0; i < 8; i++) begin
        word = 3'(i / per_word(mode_q));
        row = 2'(i % per_word(mode_q));
        addr = {1'b0, ptr_q} + {4'h0, word};
        if (addr < 7'(RW)) begin
          if (here) begin
            ram_d[addr[5:0]][row] = link.data[7 - i];
          end
        end else begin
          excess = 1'b1;
          addr = addr - 7'(RW);
          // Spill from the driver before lands here, even on the last one
          if (there && addr < 7'(RW)) begin
            ram_d[addr[5:0]][row] = link.data[7 - i];
          end
        end
      end
      nxt = {1'b0, ptr_q} + {3'h0, steps_of(mode_q)};
      if (nxt >= 7'(RW)) begin
        ptr_d = PW'(nxt - 7'(RW));
        sub_d = sub_q + 3'h1;
      end else begin
        ptr_d = nxt[PW-1:0];
      end
      // Last driver refuses when the byte reaches or passes its end
      ack_d = (here && !(nxt >= 7'(RW) && last_drv))
              || (excess && there);
    end
    rd_d = (i_ram_rd_addr < PW'(RW)) ? ram_q[i_ram_rd_addr] : 4'h0;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      phase_q <= PH_IDLE;
      ptr_q <= cascade_pkg::PTR_RESET;
      sub_q <= cascade_pkg::SUB_RESET;
      mode_q <= cascade_pkg::MODE_RESET;
      ack_q <= 1'b0;
      ram_q <= '0;
      rd_q <= 4'h0;
    end else begin
      phase_q <= phase_d;
      ptr_q <= ptr_d;
      sub_q <= sub_d;
      mode_q <= mode_d;
      ack_q <= ack_d;
      ram_q <= ram_d;
      rd_q <= rd_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Open drain: only ever pulls, never drives high
  assign link.ack_out = 1'b0;
  assign link.ack_oe = ack_q;
  assign o_ram_rd_data = rd_q;
  assign o_write_pointer = ptr_q;
  assign o_subaddr_count = sub_q;
  assign o_drive_mode = mode_q;
  assign o_frame_tick = tick_q;
endmodule : cascade_device
`default_nettype wire

// file: hdl/cascade_host.sv
// Purpose: Bus master end: queues bytes, sends them, reports acknowledge.
// Assumes: Devices answer in the cycle after each strobe.
// Notes: FIFO drains only while the sender is idle, so it can fill.
`timescale 1ns/100ps
`default_nettype none
module cascade_fifo #(
  parameter int WIDTH = cascade_pkg::FIFO_WIDTH,
  parameter int DEPTH = cascade_pkg::FIFO_DEPTH
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [DEPTH-1:0][WIDTH-1:0] mem_q, mem_d;
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  // Honest full and empty from the occupancy count
  always_comb begin
    push = i_in_valid && (cnt_q != (AW+1)'(DEPTH));
    pop = i_out_ready && (cnt_q != '0);
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    if (push) begin
      mem_d[wr_q] = i_in_data;
      wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
    end
    if (pop) begin
      rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
    end
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      mem_q <= '0;
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      mem_q <= mem_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  assign o_in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data = mem_q[rd_q];
endmodule : cascade_fifo

module cascade_host #(
  parameter int TICK_DIV = cascade_pkg::TICK_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  cascade_if.host link,
  input wire logic i_push_valid,
  input wire logic i_push_start,
  input wire logic [7:0] i_push_byte,
  output logic o_push_ready,
  output logic o_result_valid,
  output logic o_result_ack
);
  typedef enum {HS_IDLE, HS_SEND, HS_WAIT} host_state_e;

  logic f_valid, f_ready;
  logic [cascade_pkg::FIFO_WIDTH-1:0] f_data;

  // ----------------------------------------------------------------------
  // Queue in the byte path
  // ----------------------------------------------------------------------
  cascade_fifo #(
    .WIDTH(cascade_pkg::FIFO_WIDTH),
    .DEPTH(cascade_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_in_valid(i_push_valid),
    .i_in_data({i_push_start, i_push_byte}),
    .o_in_ready(o_push_ready),
    .o_out_valid(f_valid),
    .o_out_data(f_data),
    .i_out_ready(f_ready)
  );

  // ----------------------------------------------------------------------
  // Sender: strobe, then sample acknowledge in the following cycle
  // ----------------------------------------------------------------------
  host_state_e st_q, st_d;
  logic start_q, start_d, stb_q, stb_d, res_v_q, res_v_d, res_a_q, res_a_d;
  logic [7:0] data_q, data_d, div_q, div_d;
  logic clk_q, clk_d;

  always_comb begin
    st_d = st_q;
    start_d = 1'b0;
    stb_d = 1'b0;
    data_d = data_q;
    res_v_d = 1'b0;
    res_a_d = res_a_q;
    f_ready = (st_q == HS_IDLE);
    case (st_q)
      HS_IDLE: begin
        if (f_valid) begin
          stb_d = 1'b1;
          start_d = f_data[8];
          data_d = f_data[7:0];
          st_d = HS_SEND;
        end
      end
      HS_SEND: st_d = HS_WAIT;
      HS_WAIT: begin
        res_v_d = 1'b1;
        res_a_d = link.ack;
        st_d = HS_IDLE;
      end
      default: st_d = HS_IDLE;
    endcase
    // Common cascade clock made here for drivers strapped to external
    div_d = (div_q == 8'(TICK_DIV / 2 - 1)) ? 8'h00 : div_q + 8'h01;
    clk_d = (div_q == 8'(TICK_DIV / 2 - 1)) ? ~clk_q : clk_q;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      st_q <= HS_IDLE;
      start_q <= 1'b0;
      stb_q <= 1'b0;
      data_q <= 8'h00;
      res_v_q <= 1'b0;
      res_a_q <= 1'b0;
      div_q <= 8'h00;
      clk_q <= 1'b0;
    end else begin
      st_q <= st_d;
      start_q <= start_d;
      stb_q <= stb_d;
      data_q <= data_d;
      res_v_q <= res_v_d;
      res_a_q <= res_a_d;
      div_q <= div_d;
      clk_q <= clk_d;
    end
  end

  assign link.start = start_q;
  assign link.stb = stb_q;
  assign link.data = data_q;
  assign link.ext_clk = clk_q;
  assign o_result_valid = res_v_q;
  assign o_result_ack = res_a_q;
endmodule : cascade_host
`default_nettype wire

// file: verif/cascade_link_checker.sv
// Purpose: Link checks between the host and the cascaded drivers.
// Assumes: One clock; synchronous active high reset.
// Notes: ack_oe is the wired OR of every driver's enable.
`timescale 1ns/100ps
`default_nettype none
module cascade_link_checker #(
  parameter int TICK_DIV = 4
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic start,
  input wire logic stb,
  input wire logic [7:0] data,
  input wire logic ext_clk,
  input wire logic ack_out,
  input wire logic ack_oe
);
  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  logic cmd_q, cmd_d, clk_q;
  logic [7:0] run_q, run_d;

  // Command phase runs from an accepted address until C is clear
  always_comb begin
    cmd_d = cmd_q;
    if (stb && start) begin
      cmd_d = (data == 8'h70);
    end else if (stb && !data[7]) begin
      cmd_d = 1'b0;
    end
    run_d = (ext_clk != clk_q) ? 8'h00 : run_q + 8'h01;
  end

  // No saturation: a stuck cascade clock fails long before a wrap
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      cmd_q <= 1'b0;
      run_q <= 8'h00;
    end else begin
      cmd_q <= cmd_d;
      run_q <= run_d;
    end
    clk_q <= ext_clk;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  property p_ack_after_stb; ack_oe |-> $past(stb); endproperty
  a_ack_after_stb: assert property (p_ack_after_stb)
    else $error("acknowledge without a strobe one cycle before");
  property p_addr_ack; stb && start && data == 8'h70 |=> ack_oe; endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("shared slave address not acknowledged");
  property p_addr_rej; stb && start && data != 8'h70 |=> !ack_oe; endproperty
  a_addr_rej: assert property (p_addr_rej)
    else $error("foreign slave address acknowledged");
  property p_cmd_ack; stb && !start && cmd_q |=> ack_oe; endproperty
  a_cmd_ack: assert property (p_cmd_ack)
    else $error("command byte not acknowledged");
  property p_start_stb; start |-> stb; endproperty
  a_start_stb: assert property (p_start_stb)
    else $error("start flag without a byte strobe");
  property p_stb_gap; stb |=> !stb ##1 !stb; endproperty
  a_stb_gap: assert property (p_stb_gap)
    else $error("byte strobes closer than three cycles");
  property p_ack_pulse; ack_oe |=> !ack_oe; endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("acknowledge held longer than one cycle");
  property p_open_drain; ack_oe |-> !ack_out; endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("acknowledge driven high");
  property p_clk_run; int'(run_q) <= TICK_DIV; endproperty
  a_clk_run: assert property (p_clk_run)
    else $error("cascade clock stopped");
endmodule : cascade_link_checker
`default_nettype wire

// file: verif/cascade_display_ram_write_addressing_tb_top.sv
// Purpose: Bench for the host and two cascaded drivers on one link.
// Assumes: Second driver is last, strap 1 on two address bits.
// Notes: Expected RAM words come from the bit placement function.
`timescale 1ns/100ps
`default_nettype none
module cascade_display_ram_write_addressing_tb_top;
  // ----------------------------------------------------------------
  // Signals, link and instances
  // ----------------------------------------------------------------
  logic clk, srst, pv, ps, rdy, rv, ra, osc, tk0, tk1, rdy_n;
  logic last0, last1;
  logic [7:0] pb;
  logic [5:0] rd, wp0, wp1;
  logic [3:0] rw0, rw1;
  logic [2:0] sc0, sc1, st0, st1;
  logic [1:0] dm0, dm1;
  logic [7:0] q[$];
  logic acks[$];
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  cascade_if lh();
  cascade_if l0();
  cascade_if l1();
  // Host byte stream fans out; enables are wired OR onto the host
  assign l0.start = lh.start;
  assign l0.stb = lh.stb;
  assign l0.data = lh.data;
  assign l0.ext_clk = lh.ext_clk;
  assign l1.start = lh.start;
  assign l1.stb = lh.stb;
  assign l1.data = lh.data;
  assign l1.ext_clk = lh.ext_clk;
  assign lh.ack_oe = l0.ack_oe | l1.ack_oe;
  assign lh.ack_out = l0.ack_out | l1.ack_out;
  cascade_host #(.TICK_DIV(4)) cascade_host_i (.i_ref_clk(clk),
    .i_srst(srst), .link(lh.host), .i_push_valid(pv), .i_push_start(ps),
    .i_push_byte(pb), .o_push_ready(rdy), .o_result_valid(rv),
    .o_result_ack(ra));
  cascade_device #(.SUBADDR_BITS(3), .TICK_DIV(4)) cascade_device_i (
    .i_ref_clk(clk), .i_srst(srst), .link(l0.device),
    .i_subaddr_strap_bit_zero(st0[0]), .i_subaddr_strap_bit_one(st0[1]),
    .i_subaddr_strap_bit_two(st0[2]), .i_oscillator_source_select(osc),
    .i_last_in_cascade(last0), .i_ram_rd_addr(rd), .o_ram_rd_data(rw0),
    .o_write_pointer(wp0), .o_subaddr_count(sc0), .o_drive_mode(dm0),
    .o_frame_tick(tk0));
  cascade_device #(.SUBADDR_BITS(2), .TICK_DIV(4)) cascade_device_last_i (
    .i_ref_clk(clk), .i_srst(srst), .link(l1.device),
    .i_subaddr_strap_bit_zero(st1[0]), .i_subaddr_strap_bit_one(st1[1]),
    .i_subaddr_strap_bit_two(st1[2]), .i_oscillator_source_select(osc),
    .i_last_in_cascade(last1), .i_ram_rd_addr(rd), .o_ram_rd_data(rw1),
    .o_write_pointer(wp1), .o_subaddr_count(sc1), .o_drive_mode(dm1),
    .o_frame_tick(tk1));
  cascade_link_checker cascade_link_checker_i (
    .i_ref_clk(clk), .i_srst(srst), .start(lh.start), .stb(lh.stb),
    .data(lh.data), .ext_clk(lh.ext_clk), .ack_out(lh.ack_out),
    .ack_oe(lh.ack_oe));

  // ----------------------------------------------------------------
  // Clock, monitors and timeout
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Mid-cycle sampling avoids racing the edge that updates outputs
  always @(negedge clk) begin
    rdy_n = rdy;
    if (rv === 1'b1) begin
      acks.push_back(ra);
    end
    check_count++;
    if (tk0 !== tk1) begin
      errors++;
      $display("BAD frame_tick expected %b seen %b", tk0, tk1);
    end
  end

  // Whole run needs a few hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Bits MSB first; bpw bits per word, row is index within word
  function automatic logic [3:0] word(input logic [7:0] d, input int bpw,
                                      input int k);
    word = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (i / bpw == k) word[i % bpw] = d[7 - i];
    end
  endfunction : word

  task automatic push(input logic [7:0] b, input logic s);
    pv <= 1'b1;
    ps <= s;
    pb <= b;
    do @(posedge clk); while (rdy_n !== 1'b1);
  endtask : push

  // Sends queue q as one message; bit i of ae is the ack of byte i
  task automatic msg(input logic [7:0] ae);
    int k;
    acks.delete();
    foreach (q[i]) push(q[i], i == 0);
    pv <= 1'b0;
    k = 0;
    while (acks.size() < q.size() && k < 200) begin
      @(posedge clk);
      k++;
    end
    foreach (q[i]) chk("ack", {7'h0, ae[i]}, {7'h0, acks[i]});
  endtask : msg

  task automatic state(input logic [5:0] p, input logic [2:0] c);
    chk("pointer0", {2'h0, p}, {2'h0, wp0});
    chk("pointer1", {2'h0, p}, {2'h0, wp1});
    chk("count0", {5'h0, c}, {5'h0, sc0});
    chk("count1", {5'h0, c}, {5'h0, sc1});
  endtask : state

  task automatic ram(input logic [5:0] a, input logic [3:0] e0,
                     input logic [3:0] e1);
    rd <= a;
    @(posedge clk);
    #1;
    chk("ram0", {4'h0, e0}, {4'h0, rw0});
    chk("ram1", {4'h0, e1}, {4'h0, rw1});
    @(posedge clk);
  endtask : ram

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_modes();
    logic [5:0] p;
    for (int m = 0; m < 4; m++) begin
      p = 6'(m * 8);
      q = '{8'h70, 8'hE0 | 8'(m), {2'b00, p}, 8'hA5};
      msg(8'h0F);
      chk("mode", 8'(m), {6'h0, dm0});
      state(p + 6'((8 + m) / (m + 1)), 3'h0);
      for (int k = 0; k < 3; k++) begin
        ram(p + 6'(k), word(8'hA5, m + 1, k), 4'h0);
      end
    end
    $display("test modes done");
  endtask : t_modes

  task automatic t_cascade();
    q = '{8'h70, 8'hF9, 8'h1E, 8'hFF};
    msg(8'h0F);
    state(6'h20, 3'h1);
    ram(6'h1E, 4'h0, 4'hF);
    q = '{8'h70, 8'hF8, 8'h27, 8'h3C};
    msg(8'h0F);
    state(6'h01, 3'h1);
    ram(6'h00, word(8'hA5, 1, 0), word(8'h3C, 4, 1));
    q = '{8'h70, 8'hF9, 8'h26, 8'h5A};
    msg(8'h07);
    state(6'h00, 3'h2);
    ram(6'h27, word(8'h3C, 4, 0), word(8'h5A, 4, 1));
    q = '{8'h70, 8'hF9, 8'h27, 8'h96};
    msg(8'h07);
    state(6'h01, 3'h2);
    ram(6'h27, word(8'h3C, 4, 0), word(8'h96, 4, 0));
    ram(6'h00, word(8'hA5, 1, 0), word(8'h3C, 4, 1));
    q = '{8'h72, 8'h05};
    msg(8'h00);
    state(6'h01, 3'h2);
    $display("test cascade done");
  endtask : t_cascade

  // Queue is pushed every cycle while the sender drains one per three
  task automatic t_fifo();
    int n;
    int k;
    n = 0;
    k = 0;
    acks.delete();
    pv <= 1'b1;
    ps <= 1'b1;
    pb <= 8'h70;
    while (k < 60) begin
      @(posedge clk);
      k++;
      if (rdy_n !== 1'b1) break;
      n++;
      ps <= 1'b0;
      pb <= 8'h81;
    end
    pv <= 1'b0;
    chk("ready", 8'h00, {7'h0, rdy_n});
    k = 0;
    while (acks.size() < n && k < 400) begin
      @(posedge clk);
      k++;
    end
    chk("results", 8'(n), 8'(acks.size()));
    foreach (acks[i]) chk("ack", 8'h01, {7'h0, acks[i]});
    state(6'h01, 3'h2);
    $display("test fifo done");
  endtask : t_fifo

  // Internal divider, then shared clock: one tick per TICK_DIV cycles
  task automatic t_tick();
    int n0;
    int n1;
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      osc <= 1'(s);
      repeat (8) @(posedge clk);
      n0 = 0;
      n1 = 0;
      repeat (40) begin
        @(posedge clk);
        #1;
        n0 += tk0;
        n1 += tk1;
      end
      chk("ticks0", 8'h0A, 8'(n0));
      chk("ticks1", 8'h0A, 8'(n1));
    end
    $display("test tick done");
  endtask : t_tick

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  // Straps are set during reset so the sync stages settle
  initial begin
    srst = 1'b1;
    pv = 1'b0;
    ps = 1'b0;
    pb = 8'h00;
    rd = 6'h00;
    osc = 1'b1;
    last0 = 1'b0;
    last1 = 1'b1;
    st0 = 3'b000;
    st1 = 3'b101;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    state(6'h00, 3'h0);
    chk("mode", 8'h03, {6'h0, dm0});
    ram(6'h05, 4'h0, 4'h0);
    t_modes();
    t_cascade();
    t_fifo();
    t_tick();
    end_of_test();
  end
endmodule : cascade_display_ram_write_addressing_tb_top
`default_nettype wire
